// ---- verilog/psg_pkg.sv ----
// constants and field layout for the pattern sync pulse generator
// ****************************************************************
// Notes on behaviour
// - repeat mode outputs pattern continuously
// - burst mode transmits pattern as bursts
// - burst only for prbs, zero-run, user, mixed-data
// - repeat: pulse high width bits per period
// - width must be multiple of eight
// - pulse start delayed by programmed bit count
// - delay must be multiple of eight
// - single channel: 128 to lcm minus 128
// - single channel limit capped at 34359738240
// - merged: 256 to lcm minus 256, step 16
// - merged limit capped at 68719476480
// - mixed: 128 to product minus 128, capped
// - mixed merged: 256 to product minus 256
// - single: extend short length to 512 or more
// - merged: extend short length to 1024 or more
// - settings shared by both data outputs
// - length taken from first data output
// - burst: gating output carries burst trigger
// ****************************************************************
package psg_pkg;
    localparam int CW = 40;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PLEN = 8'h04;
    localparam logic [7:0] OFF_ROW_LEN = 8'h08;
    localparam logic [7:0] OFF_ROW_CNT = 8'h0C;
    localparam logic [7:0] OFF_BLK_CNT = 8'h10;
    localparam logic [7:0] OFF_WIDTH_LO = 8'h14;
    localparam logic [7:0] OFF_WIDTH_HI = 8'h18;
    localparam logic [7:0] OFF_DELAY_LO = 8'h1C;
    localparam logic [7:0] OFF_DELAY_HI = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_PERIOD_LO = 8'h28;
    localparam logic [7:0] OFF_PERIOD_HI = 8'h2C;
    // ************************************************************
    // control field positions and pattern type codes
    // ************************************************************
    localparam int CTRL_BURST_BIT = 0;
    localparam int CTRL_MERGE_BIT = 1;
    localparam int CTRL_PAT_LSB = 2;
    localparam logic [2:0] PAT_PRBS = 3'h0;
    localparam logic [2:0] PAT_ZERO_RUN = 3'h1;
    localparam logic [2:0] PAT_USER = 3'h2;
    localparam logic [2:0] PAT_MIX_DATA = 3'h3;
    localparam logic [2:0] PAT_MIX_PRBS = 3'h4;
    localparam logic [2:0] PAT_OTHER = 3'h5;
    // ************************************************************
    // limits, steps and reset values
    // ************************************************************
    localparam logic [CW-1:0] BASE_SINGLE = 40'h00_0000_0080;
    localparam logic [CW-1:0] BASE_MERGED = 40'h00_0000_0100;
    localparam logic [CW-1:0] CAP_SINGLE = 40'h07_FFFF_FF80;
    localparam logic [CW-1:0] CAP_MERGED = 40'h0F_FFFF_FF00;
    localparam logic [CW-1:0] CAP_MIXED = 40'h00_8FFF_FF80;
    localparam logic [CW-1:0] CAP_NONE = 40'hFF_FFFF_FFFF;
    localparam logic [CW-1:0] EXT_SINGLE = 40'h00_0000_0200;
    localparam logic [CW-1:0] EXT_MERGED = 40'h00_0000_0400;
    localparam logic [CW-1:0] STEP_SINGLE = 40'h00_0000_0008;
    localparam logic [CW-1:0] STEP_MERGED = 40'h00_0000_0010;
    localparam logic [3:0] LCM_POW_SINGLE = 4'h7;
    localparam logic [3:0] LCM_POW_MERGED = 4'h8;
    localparam logic [31:0] RST_PLEN = 32'h0000_007F;
    localparam logic [15:0] RST_MIX_DIM = 16'h0001;
    localparam logic [CW-1:0] RST_WIDTH = 40'h00_0000_0080;
    localparam logic [CW-1:0] RST_DELAY = 40'h00_0000_0080;
    localparam logic [4:0] RST_CTRL = 5'h00;
endpackage

// ---- verilog/psg_period_calc.sv ----
// extends a short pattern length and forms the pulse period in bits
`timescale 1ns/10ps
module psg_period_calc
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic [31:0] len,
    input wire logic merged,
    output logic [psg_pkg::CW-1:0] period,
    output logic busy
);
    import psg_pkg::*;

    typedef enum logic {PSG_CALC_IDLE, PSG_CALC_EXTEND} psg_calc_state_t;

    psg_calc_state_t state_reg;
    logic [CW-1:0] acc_reg;
    logic [CW-1:0] period_reg;
    logic [CW-1:0] len_w;
    logic [CW-1:0] ext_min;
    logic [3:0] pow;
    logic [3:0] tz;
    logic [CW-1:0] lcm_w;

    // zero length would never reach the minimum, so count it as one bit
    assign len_w = (len == 32'h0000_0000) ? 40'h00_0000_0001 : {8'h00, len};
    assign ext_min = merged ? EXT_MERGED : EXT_SINGLE;
    assign pow = merged ? LCM_POW_MERGED : LCM_POW_SINGLE;

    // trailing zeros, clipped at the power: gcd with a power of two
    always_comb
    begin
        tz = pow;
        for (int i = 7; i >= 0; i--)
        begin
            if (acc_reg[i] && (4'(i) < tz))
            begin
                tz = 4'(i);
            end
        end
    end

    // lcm(L, 2^pow) = L << (pow - min(tz, pow))
    assign lcm_w = acc_reg << (pow - tz);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= PSG_CALC_IDLE;
            acc_reg <= 40'h00_0000_0000;
            period_reg <= 40'h00_0000_0000;
        end
        else
        begin
            case (state_reg)
                PSG_CALC_IDLE:
                begin
                    if (start)
                    begin
                        // start from zero: the length register may be written on this same edge
                        acc_reg <= 40'h00_0000_0000;
                        state_reg <= PSG_CALC_EXTEND;
                    end
                end
                PSG_CALC_EXTEND:
                begin
                    // one multiple per cycle; a one-bit length needs 1025 cycles when merged, 513 when not
                    if (start)
                    begin
                        acc_reg <= 40'h00_0000_0000;
                    end
                    else if (acc_reg >= ext_min)
                    begin
                        period_reg <= lcm_w;
                        state_reg <= PSG_CALC_IDLE;
                    end
                    else
                    begin
                        acc_reg <= acc_reg + len_w;
                    end
                end
                default:
                begin
                    state_reg <= PSG_CALC_IDLE;
                end
            endcase
        end
    end

    assign period = period_reg;
    assign busy = (state_reg == PSG_CALC_EXTEND);
endmodule // psg_period_calc

// ---- verilog/psg_sync_gen.sv ----
// pattern sync pulse generator top with apb register slave
`timescale 1ns/10ps
module psg_sync_gen
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic burst_trig_in,
    output logic gate_out,
    output logic pat_repeat,
    output logic pat_burst,
    output logic pat_start
);
    import psg_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    // one set of settings serves both data outputs
    logic [4:0] ctrl_reg;
    logic [31:0] plen_reg;
    logic [15:0] row_len_reg;
    logic [15:0] row_cnt_reg;
    logic [15:0] blk_cnt_reg;
    logic [CW-1:0] width_reg;
    logic [CW-1:0] delay_reg;
    logic [31:0] wlo_stage_reg;
    logic [31:0] dlo_stage_reg;
    logic err_width_reg;
    logic err_delay_reg;
    logic err_seq_reg;
    logic [CW-1:0] cnt_reg;
    logic gate_reg;
    logic start_reg;
    logic [31:0] prdata_reg;
    logic restart_reg;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic acc_w;
    logic wr_w;
    logic setup_w;
    logic hit_w;
    logic wr_ctrl;
    logic wr_plen;
    logic wr_row_len;
    logic wr_row_cnt;
    logic wr_blk_cnt;
    logic wr_width_lo;
    logic wr_width_hi;
    logic wr_delay_lo;
    logic wr_delay_hi;
    logic wr_status;

    assign acc_w = psel && penable;
    assign wr_w = acc_w && pwrite;
    assign setup_w = psel && !penable;
    assign hit_w = (paddr[1:0] == 2'h0) && (paddr <= OFF_PERIOD_HI);
    assign wr_ctrl = wr_w && (paddr == OFF_CTRL);
    assign wr_plen = wr_w && (paddr == OFF_PLEN);
    assign wr_row_len = wr_w && (paddr == OFF_ROW_LEN);
    assign wr_row_cnt = wr_w && (paddr == OFF_ROW_CNT);
    assign wr_blk_cnt = wr_w && (paddr == OFF_BLK_CNT);
    assign wr_width_lo = wr_w && (paddr == OFF_WIDTH_LO);
    assign wr_width_hi = wr_w && (paddr == OFF_WIDTH_HI);
    assign wr_delay_lo = wr_w && (paddr == OFF_DELAY_LO);
    assign wr_delay_hi = wr_w && (paddr == OFF_DELAY_HI);
    assign wr_status = wr_w && (paddr == OFF_STATUS);

    // zero wait states: every access completes in its first access cycle
    assign pready = acc_w;
    assign pslverr = acc_w && !hit_w;

    // ************************************************************
    // mode decode
    // ************************************************************
    logic burst_w;
    logic merged_w;
    logic [2:0] pat_w;
    logic [2:0] pat_new;
    logic mixed_w;
    logic burst_ok_new;
    logic ctrl_ok;

    assign burst_w = ctrl_reg[CTRL_BURST_BIT];
    assign merged_w = ctrl_reg[CTRL_MERGE_BIT];
    assign pat_w = ctrl_reg[CTRL_PAT_LSB +: 3];
    assign mixed_w = (pat_w == PAT_MIX_DATA) || (pat_w == PAT_MIX_PRBS);
    assign pat_new = pwdata[CTRL_PAT_LSB +: 3];
    assign burst_ok_new = (pat_new == PAT_PRBS) || (pat_new == PAT_ZERO_RUN) ||
                          (pat_new == PAT_USER) || (pat_new == PAT_MIX_DATA);
    // burst with any other pattern type is refused whole
    assign ctrl_ok = !pwdata[CTRL_BURST_BIT] || burst_ok_new;

    // ************************************************************
    // period and limits
    // ************************************************************
    logic calc_start;
    logic calc_busy;
    logic [CW-1:0] calc_period;
    logic [47:0] mix_prod;
    logic [CW-1:0] mix_period;
    logic [CW-1:0] period_w;
    logic [CW-1:0] base_w;
    logic [CW-1:0] cap_w;
    logic [CW-1:0] step_w;
    logic [CW-1:0] span_w;
    logic [CW-1:0] lim_w;
    logic [CW-1:0] width_new;
    logic [CW-1:0] delay_new;
    logic width_ok;
    logic delay_ok;

    // length always comes from the first data output's setting
    assign calc_start = (wr_ctrl && ctrl_ok) || wr_plen;

    psg_period_calc u_calc
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(calc_start),
        .len(plen_reg),
        .merged(merged_w),
        .period(calc_period),
        .busy(calc_busy)
    );

    assign mix_prod = 48'(row_len_reg) * 48'(row_cnt_reg) * 48'(blk_cnt_reg);
    // a product beyond the counter width saturates; the cap limits it only when not merged
    assign mix_period = (mix_prod[47:CW] != 8'h00) ? CAP_NONE : mix_prod[CW-1:0];
    assign period_w = mixed_w ? mix_period : calc_period;
    assign base_w = merged_w ? BASE_MERGED : BASE_SINGLE;
    assign step_w = merged_w ? STEP_MERGED : STEP_SINGLE;
    assign cap_w = mixed_w ? (merged_w ? CAP_NONE : CAP_MIXED) :
                   (merged_w ? CAP_MERGED : CAP_SINGLE);
    assign span_w = (period_w > base_w) ? (period_w - base_w) : 40'h00_0000_0000;
    assign lim_w = (span_w < cap_w) ? span_w : cap_w;

    assign width_new = {pwdata[7:0], wlo_stage_reg};
    assign delay_new = {pwdata[7:0], dlo_stage_reg};
    // step of 8 or 16 also enforces the multiple of eight
    assign width_ok = (width_new >= base_w) && (width_new <= lim_w) &&
                      ((width_new & (step_w - 40'h00_0000_0001)) == 40'h00_0000_0000);
    assign delay_ok = (delay_new >= base_w) && (delay_new <= lim_w) &&
                      ((delay_new & (step_w - 40'h00_0000_0001)) == 40'h00_0000_0000);

    // ************************************************************
    // registers written by software
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_reg <= RST_CTRL;
            plen_reg <= RST_PLEN;
            row_len_reg <= RST_MIX_DIM;
            row_cnt_reg <= RST_MIX_DIM;
            blk_cnt_reg <= RST_MIX_DIM;
            wlo_stage_reg <= 32'h0000_0000;
            dlo_stage_reg <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl && ctrl_ok)
                ctrl_reg <= pwdata[4:0];
            if (wr_plen)
                plen_reg <= pwdata;
            if (wr_row_len)
                row_len_reg <= pwdata[15:0];
            if (wr_row_cnt)
                row_cnt_reg <= pwdata[15:0];
            if (wr_blk_cnt)
                blk_cnt_reg <= pwdata[15:0];
            if (wr_width_lo)
                wlo_stage_reg <= pwdata;
            if (wr_delay_lo)
                dlo_stage_reg <= pwdata;
        end
    end

    // the value takes effect only on the high half write, and only if legal
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            width_reg <= RST_WIDTH;
            delay_reg <= RST_DELAY;
        end
        else
        begin
            if (wr_width_hi && width_ok)
                width_reg <= width_new;
            if (wr_delay_hi && delay_ok)
                delay_reg <= delay_new;
        end
    end

    // ************************************************************
    // refusal flags: set wins over the write-one clear
    // ************************************************************
    logic set_ew;
    logic set_ed;
    logic set_es;

    assign set_ew = wr_width_hi && !width_ok;
    assign set_ed = wr_delay_hi && !delay_ok;
    assign set_es = wr_ctrl && !ctrl_ok;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            err_width_reg <= 1'b0;
            err_delay_reg <= 1'b0;
            err_seq_reg <= 1'b0;
        end
        else
        begin
            err_width_reg <= set_ew || (err_width_reg && !(wr_status && pwdata[0]));
            err_delay_reg <= set_ed || (err_delay_reg && !(wr_status && pwdata[1]));
            err_seq_reg <= set_es || (err_seq_reg && !(wr_status && pwdata[2]));
        end
    end

    // ************************************************************
    // pattern period counter
    // ************************************************************
    logic cfg_wr;
    logic run_w;
    logic [CW-1:0] cnt_inc;
    logic [CW-1:0] cnt_next;

    assign cfg_wr = wr_ctrl || wr_plen || wr_row_len || wr_row_cnt || wr_blk_cnt ||
                    wr_width_hi || wr_delay_hi;
    // counter holds at zero while the period is being worked out
    assign run_w = !calc_busy && !restart_reg && (period_w != 40'h00_0000_0000);
    assign cnt_inc = cnt_reg + step_w;
    assign cnt_next = !run_w ? 40'h00_0000_0000 :
                      (cnt_inc >= period_w) ? 40'h00_0000_0000 : cnt_inc;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            restart_reg <= 1'b1;
            cnt_reg <= 40'h00_0000_0000;
        end
        else
        begin
            restart_reg <= cfg_wr;
            cnt_reg <= cnt_next;
        end
    end

    // ************************************************************
    // pulse window and gating output
    // ************************************************************
    logic [CW:0] end_w;
    logic [CW:0] end_wrap;
    logic wraps_w;
    logic hit_pulse;

    // window [delay, delay+width) taken modulo the period
    assign end_w = {1'b0, delay_reg} + {1'b0, width_reg};
    assign wraps_w = end_w > {1'b0, period_w};
    assign end_wrap = end_w - {1'b0, period_w};
    assign hit_pulse = run_w && (wraps_w ?
                       ((cnt_reg >= delay_reg) || ({1'b0, cnt_reg} < end_wrap)) :
                       ((cnt_reg >= delay_reg) && ({1'b0, cnt_reg} < end_w)));

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            // burst mode hands the connector to the burst trigger
            gate_reg <= burst_w ? burst_trig_in : hit_pulse;
            start_reg <= run_w && (cnt_reg == 40'h00_0000_0000);
        end
    end

    assign gate_out = gate_reg;
    assign pat_start = start_reg;
    assign pat_repeat = !burst_w;
    assign pat_burst = burst_w;

    // ************************************************************
    // read back, captured in the setup cycle
    // ************************************************************
    logic [31:0] rd_w;

    always_comb
    begin
        case (paddr)
            OFF_CTRL: rd_w = {27'h000_0000, ctrl_reg};
            OFF_PLEN: rd_w = plen_reg;
            OFF_ROW_LEN: rd_w = {16'h0000, row_len_reg};
            OFF_ROW_CNT: rd_w = {16'h0000, row_cnt_reg};
            OFF_BLK_CNT: rd_w = {16'h0000, blk_cnt_reg};
            OFF_WIDTH_LO: rd_w = width_reg[31:0];
            OFF_WIDTH_HI: rd_w = {24'h00_0000, width_reg[CW-1:32]};
            OFF_DELAY_LO: rd_w = delay_reg[31:0];
            OFF_DELAY_HI: rd_w = {24'h00_0000, delay_reg[CW-1:32]};
            OFF_STATUS: rd_w = {27'h000_0000, gate_reg, calc_busy, err_seq_reg, err_delay_reg, err_width_reg};
            OFF_PERIOD_LO: rd_w = period_w[31:0];
            OFF_PERIOD_HI: rd_w = {24'h00_0000, period_w[CW-1:32]};
            default: rd_w = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prdata_reg <= 32'h0000_0000;
        else if (setup_w)
            prdata_reg <= rd_w;
    end

    assign prdata = prdata_reg;
endmodule // psg_sync_gen

// ---- tb/psg_sync_gen_properties.sv ----
// port assertions for the sync pulse generator
`timescale 1ns/10ps
module psg_sync_gen_properties
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic burst_trig_in,
    input wire logic gate_out,
    input wire logic pat_repeat,
    input wire logic pat_burst,
    input wire logic pat_start
);
    import psg_pkg::*;
    // ************
    // bus and mode checks
    // ************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence ctrl_wr;
        psel && penable && pwrite && paddr == OFF_CTRL;
    endsequence
    sequence burst_req(logic ok);
        ctrl_wr ##0 pwdata[CTRL_BURST_BIT] && ((pwdata[CTRL_PAT_LSB +: 3] <= PAT_MIX_DATA) == ok);
    endsequence
    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready missing in access");
    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    unmapped_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    mode_excl_a: assert property (pat_repeat != pat_burst)
        else $error("repeat and burst not exclusive");
    repeat_sel_a: assert property (ctrl_wr ##0 !pwdata[CTRL_BURST_BIT] |=> pat_repeat)
        else $error("repeat write not taken");
    burst_sel_a: assert property (burst_req(1'b1) |=> pat_burst)
        else $error("legal burst write not taken");
    burst_refuse_a: assert property (burst_req(1'b0) |=> $stable(pat_burst))
        else $error("illegal burst write taken");
    burst_gate_a: assert property (pat_burst && $past(pat_burst) |-> gate_out == $past(burst_trig_in))
        else $error("gate does not carry burst trigger");
    reset_quiet_a: assert property ($rose(nrst) |-> !gate_out && !pat_start)
        else $error("gate active right after reset");
endmodule // psg_sync_gen_properties
bind psg_sync_gen psg_sync_gen_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .burst_trig_in(burst_trig_in), .gate_out(gate_out), .pat_repeat(pat_repeat), .pat_burst(pat_burst),
    .pat_start(pat_start));

// ---- tb/psg_gate_probe.sv ----
// test equipment model that measures the gating pulse in clock cycles
`timescale 1ns/10ps
module psg_gate_probe
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic gate_out,
    input wire logic pat_start,
    output logic [31:0] hi_len,
    output logic [31:0] dly_len,
    output logic [31:0] per_len,
    output logic [31:0] n_rise
);
    logic gate_q;
    logic [31:0] run;
    logic [31:0] since_start;
    logic [31:0] since_rise;
    // only samples, never drives: first period after a restart is not trusted by callers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_q <= 1'b0;
            run <= '0;
            since_start <= '0;
            since_rise <= '0;
            hi_len <= '0;
            dly_len <= '0;
            per_len <= '0;
            n_rise <= '0;
        end
        else
        begin
            gate_q <= gate_out;
            since_start <= pat_start ? 32'h0000_0001 : since_start + 1;
            since_rise <= (gate_out && !gate_q) ? 32'h0000_0001 : since_rise + 1;
            run <= gate_out ? run + 1 : '0;
            if (gate_out && !gate_q)
            begin
                dly_len <= since_start;
                per_len <= since_rise;
                n_rise <= n_rise + 1;
            end
            if (!gate_out && gate_q)
                hi_len <= run;
        end
    end
endmodule // psg_gate_probe

// ---- tb/test_psg_sync_gen.sv ----
// self-checking bench for the sync pulse generator
`timescale 1ns/10ps
module test_psg_sync_gen;
    import psg_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic burst_trig_in = 1'b0;
    logic [31:0] prdata, hi_len, dly_len, per_len, n_rise, q, len;
    logic pready, pslverr, gate_out, pat_repeat, pat_burst, pat_start, e, b;
    logic [31:0] rnd = 32'h0000_0056;
    logic [39:0] w, d, st, bs, p;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 clk_sys = ~clk_sys;
    psg_sync_gen uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .burst_trig_in(burst_trig_in), .gate_out(gate_out), .pat_repeat(pat_repeat), .pat_burst(pat_burst),
        .pat_start(pat_start));
    psg_gate_probe probe (.clk_sys(clk_sys), .nrst(nrst), .gate_out(gate_out), .pat_start(pat_start),
        .hi_len(hi_len), .dly_len(dly_len), .per_len(per_len), .n_rise(n_rise));
    // ************
    // helpers
    // ************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [31:0] ctrl(input logic bu, input logic mg, input logic [2:0] pt);
        return {27'h000_0000, pt, mg, bu};
    endfunction
    // short patterns are repeated up to the floor before the lcm is taken
    function automatic logic [39:0] period_of(input logic [31:0] ln, input logic mg);
        logic [39:0] l;
        logic [39:0] a;
        logic [39:0] c;
        logic [39:0] t;
        l = ln;
        while (l < (mg ? 40'h00_0000_0400 : 40'h00_0000_0200))
            l = l + ln;
        a = l;
        c = mg ? 40'h00_0000_0100 : 40'h00_0000_0080;
        while (c != 0)
        begin
            t = a % c;
            a = c;
            c = t;
        end
        return l / a * (mg ? 40'h00_0000_0100 : 40'h00_0000_0080);
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr40(input logic [7:0] lo, input logic [39:0] v);
        apb(1'b1, lo, v[31:0]);
        apb(1'b1, lo + 8'h04, {24'h00_0000, v[39:32]});
    endtask
    task automatic wait_rises(input int k);
        int n0;
        n0 = n_rise;
        while (n_rise < n0 + k)
            @(posedge clk_sys);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard: whole run needs well under this many cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            complete_run();
        end
    end
    // ************
    // scenarios
    // ************
    initial
    begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        chk({pat_repeat, gate_out}, 2'b10);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk({e, q}, {1'b1, 32'h0000_0000});
        apb(1'b1, 8'h05, 32'h0000_0001);
        chk(e, 1'b1);
        for (int m = 0; m < 2; m++)
        begin
            st = m ? STEP_MERGED : STEP_SINGLE;
            bs = m ? BASE_MERGED : BASE_SINGLE;
            apb(1'b1, OFF_ROW_LEN, 32'h0000_0080);
            apb(1'b1, OFF_ROW_CNT, m ? 32'h0000_0008 : 32'h0000_0004);
            apb(1'b1, OFF_BLK_CNT, 32'h0000_0001);
            apb(1'b1, OFF_CTRL, ctrl(1'b0, m[0], PAT_MIX_DATA));
            rnd = xs(rnd);
            w = m ? bs + st * (rnd % 33) : 3 * bs;
            rnd = xs(rnd);
            d = bs + st * (rnd % 33);
            wr40(OFF_WIDTH_LO, w);
            wr40(OFF_DELAY_LO, d);
            wait_rises(4);
            chk(hi_len, w / st);
            chk(dly_len, d / st);
            chk(per_len, 40'h00_0000_0040);
            wr40(OFF_WIDTH_LO, w + st / 2);
            wr40(OFF_DELAY_LO, bs - st);
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            chk(q[1:0], 2'b11);
            apb(1'b1, OFF_STATUS, 32'h0000_0003);
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            chk(q[1:0], 2'b00);
            wait_rises(4);
            chk(hi_len, w / st);
        end
        for (int k = 0; k < 5; k++)
        begin
            rnd = xs(rnd);
            len = k < 2 ? 32'h0000_007F : k == 2 ? 32'h0000_01FF : 32'(rnd % 2000 + 1);
            apb(1'b1, OFF_CTRL, ctrl(1'b0, k[0], PAT_PRBS));
            apb(1'b1, OFF_PLEN, len);
            do
                apb(1'b0, OFF_STATUS, 32'h0000_0000);
            while (q[3] !== 1'b0);
            apb(1'b0, OFF_PERIOD_LO, 32'h0000_0000);
            p[31:0] = q;
            apb(1'b0, OFF_PERIOD_HI, 32'h0000_0000);
            p[39:32] = q[7:0];
            chk(p, period_of(len, k[0]));
        end
        for (int c = 0; c < 6; c++)
        begin
            apb(1'b1, OFF_CTRL, ctrl(1'b0, 1'b0, PAT_PRBS));
            apb(1'b1, OFF_CTRL, ctrl(1'b1, 1'b0, 3'(c)));
            chk(pat_burst, c < 4);
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            chk(q[2], c > 3);
            apb(1'b1, OFF_STATUS, 32'h0000_0004);
            repeat (12)
            begin
                rnd = xs(rnd);
                burst_trig_in <= rnd[0];
                b = rnd[0];
                @(posedge clk_sys);
                @(negedge clk_sys);
                if (c < 4)
                    chk(gate_out, b);
                @(posedge clk_sys);
            end
            burst_trig_in <= 1'b0;
        end
        apb(1'b1, OFF_CTRL, ctrl(1'b1, 1'b0, PAT_USER));
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({pat_repeat, pat_burst, gate_out}, 3'b100);
        nrst <= 1'b1;
        @(posedge clk_sys);
        complete_run();
    end
endmodule // test_psg_sync_gen
